// File: hw/axis_check.sv
// Per-axis in-position, overflow, direction and speed ceiling evaluation
`timescale 1ns/1ps
module axis_check
  import axis_supervisor_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstN,
  // Motion inputs
  input  wire logic signed [POS_W-1:0] targetPos,
  input  wire logic signed [POS_W-1:0] currentPos,
  input  wire logic                    cmdReached,
  input  wire logic                    moveNegative,
  input  wire logic [SPD_W-1:0]        cmdSpeed,
  // Settings
  input  wire logic                    dirSetting,
  input  wire logic [SPD_W-1:0]        maxSpeed,
  input  wire logic [LIM_W-1:0]        inPosLimit,
  input  wire logic [LIM_W-1:0]        overflowLimit,
  // Results
  output logic                         inPosition_q,
  output logic                         overflow_q,
  output logic                         motorCcw_q,
  output logic [SPD_W-1:0]             speedOut_q
);

  logic [POS_W:0] diff;
  logic [POS_W:0] mag;
  logic           nearTarget;
  logic           beyondLimit;

  assign diff        = {targetPos[POS_W-1], targetPos} - {currentPos[POS_W-1], currentPos};
  assign mag         = diff[POS_W] ? (~diff + 33'h1) : diff;
  assign nearTarget  = mag < {17'h0, inPosLimit};
  assign beyondLimit = mag > {17'h0, overflowLimit};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      inPosition_q <= 1'b0;
      overflow_q   <= 1'b0;
      motorCcw_q   <= 1'b0;
      speedOut_q   <= '0;
    end else begin
      // A large threshold alone never completes a move
      inPosition_q <= cmdReached && nearTarget;
      overflow_q   <= beyondLimit;
      motorCcw_q   <= moveNegative ^ dirSetting;
      speedOut_q   <= (cmdSpeed > maxSpeed) ? maxSpeed : cmdSpeed;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  AST_INPOS_NEEDS_REACH: assert property (!cmdReached |=> !inPosition_q)
    else $error("in-position raised before command reached target");
  AST_INPOS_NEEDS_NEAR: assert property (cmdReached && !nearTarget |=> !inPosition_q)
    else $error("in-position raised with deflection at or above threshold");
  AST_OVERFLOW: assert property (beyondLimit |=> overflow_q ##1 (overflow_q || !$past(beyondLimit)))
    else $error("deflection above limit without overflow");
  AST_DIRECTION: assert property (!moveNegative && !dirSetting |=> !motorCcw_q)
    else $error("forward setting did not give clockwise rotation");
  AST_SPEED_CEIL: assert property (##1 speedOut_q <= $past(maxSpeed))
    else $error("commanded speed above ceiling");

endmodule : axis_check

// File: hw/axis_position_supervisor.sv
// Top of the four-axis positioning supervisor with its register port
// What this block does
// - Positioning completes only when target reached and deflection below threshold.
// - Overflow error when deflection exceeds the configured limit, 1 to 65535 pulses.
// - Direction 0 rotates clockwise for positive moves, 1 counterclockwise.
// - Every commanded speed is capped by the per-axis maximum, 1 to 9999.
// - Three home speeds per axis; low and medium to 250.0, high to 999.0.
// - Home speeds drop their fractional part before use.
// - High-speed homing uses the last selected acceleration table, entry 5 by default.
// - Method codes 0 to 4 accepted; code 4 behaves as code 0.
// - Sensor polarity 1 means low output detects origin; 0 means high detects.
// - Unused axes always show the question-mark label.
// - Duplicate labels in a task route servo and output commands to lowest station.
`timescale 1ns/1ps
module axis_position_supervisor
  import axis_supervisor_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0]            regAddr,
  input  wire logic [DATA_W-1:0]            regWrData,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic [DATA_W-1:0]                 regRdData_q,
  // Motion from the sequencer
  input  wire logic [AXES-1:0][POS_W-1:0]   targetPos,
  input  wire logic [AXES-1:0][POS_W-1:0]   currentPos,
  input  wire logic [AXES-1:0]              cmdReached,
  input  wire logic [AXES-1:0]              moveNegative,
  input  wire logic [AXES-1:0][SPD_W-1:0]   cmdSpeed,
  // Axis commands
  input  wire logic                         cmdValid,
  input  wire command_type                  cmdKind,
  input  wire logic [LBL_W-1:0]             cmdLabel,
  input  wire logic [TASK_W-1:0]            cmdTask,
  input  wire logic                         accelTableSelectCommand,
  input  wire logic [ACC_W-1:0]             accelTableIndex,
  // Origin sensors (pins)
  input  wire logic [AXES-1:0]              originSensor,
  // Axis results
  output logic [AXES-1:0]                   inPosition,
  output logic [AXES-1:0]                   overflowErr,
  output logic [AXES-1:0]                   motorCcw,
  output logic [AXES-1:0][SPD_W-1:0]        speedOut,
  output logic [AXES-1:0]                   originDetected_q,
  output logic [AXES-1:0][LBL_W-1:0]        displayLabel_q,
  output logic [AXES-1:0][2:0]              homeMethod_q,
  output logic [AXES-1:0][SPD_W-1:0]        homeSpeedLow_q,
  output logic [AXES-1:0][SPD_W-1:0]        homeSpeedMed_q,
  output logic [AXES-1:0][SPD_W-1:0]        homeSpeedHigh_q,
  output logic [ACC_W-1:0]                  homeAccelIndex_q,
  // Routed commands, one-hot pulses
  output logic [AXES-1:0]                   servoOnCommand_q,
  output logic [AXES-1:0]                   servoOffCommand_q,
  output logic [AXES-1:0]                   outputSetCommand_q,
  // Interrupt
  output logic                              irq
);

  logic                           rstMeta_q;
  logic                           rstN;
  logic [AXES-1:0]                originMeta_q;
  logic [AXES-1:0]                originSync_q;
  logic [AXES-1:0][LBL_W-1:0]     label_q;
  logic [AXES-1:0][LIM_W-1:0]     inPosLimit_q;
  logic [AXES-1:0][LIM_W-1:0]     overflowLimit_q;
  logic [AXES-1:0]                dir_q;
  logic [AXES-1:0][SPD_W-1:0]     maxSpeed_q;
  logic [AXES-1:0][2:0][LIM_W-1:0] homeTenths_q;
  logic [AXES-1:0][2:0]           method_q;
  logic [AXES-1:0]                sensLogic_q;
  logic [AXES-1:0][TASK_W-1:0]    task_q;
  logic [AXES-1:0]                used_q;
  logic [IRQ_W-1:0]               irqStatus_q;
  logic [IRQ_W-1:0]               irqMask_q;
  logic [AXES-1:0]                inPosPrev_q;
  logic [AXES-1:0]                overflowPrev_q;
  logic [IRQ_W-1:0]               irqEvents;
  logic [AXES-1:0]                routeHit;
  logic [AXES-1:0][LBL_W-1:0]     effLabel;
  logic [2:0]                     blockSel;
  logic [3:0]                     fieldSel;
  logic [1:0]                     axisSel;
  logic                           axisWr;
  logic                           globalWr;
  logic                           statusRd;
  logic [LIM_W-1:0]               wrLow;

  assign blockSel = regAddr[6:4];
  assign fieldSel = regAddr[3:0];
  assign axisSel  = regAddr[5:4];
  assign axisWr   = regWr && !regAddr[7] && blockSel < GLOBAL_BLOCK;
  assign globalWr = regWr && !regAddr[7] && blockSel == GLOBAL_BLOCK;
  assign statusRd = regRd && !regAddr[7] && blockSel == GLOBAL_BLOCK && fieldSel == GLB_IRQ_STAT;
  assign wrLow    = regWrData[LIM_W-1:0];

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  // Sensor pins are asynchronous to clk
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      originMeta_q <= '0;
      originSync_q <= '0;
    end else begin
      originMeta_q <= originSensor;
      originSync_q <= originMeta_q;
    end
  end

  // Per-axis settings; out-of-range writes are dropped and the old value kept
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < AXES; i++) begin
        label_q[i]         <= LABEL_NONE;
        inPosLimit_q[i]    <= RST_INPOS;
        overflowLimit_q[i] <= RST_OVERFLOW;
        dir_q[i]           <= RST_DIR;
        maxSpeed_q[i]      <= RST_MAXSPEED;
        homeTenths_q[i][0] <= RST_HOME_L;
        homeTenths_q[i][1] <= RST_HOME_M;
        homeTenths_q[i][2] <= RST_HOME_H;
        method_q[i]        <= RST_METHOD;
        sensLogic_q[i]     <= RST_SENSLOG;
        task_q[i]          <= '0;
      end
    end else if (axisWr) begin
      unique case (fieldSel)
        FLD_LABEL: begin
          if (regWrData[LBL_W-1:0] <= LABEL_NONE && regWrData[31:LBL_W] == '0) begin
            label_q[axisSel] <= regWrData[LBL_W-1:0];
          end
        end
        FLD_INPOS: begin
          if (wrLow != '0 && wrLow <= INPOS_MAX && regWrData[31:LIM_W] == '0) begin
            inPosLimit_q[axisSel] <= wrLow;
          end
        end
        FLD_OVERFLOW: begin
          if (wrLow != '0 && regWrData[31:LIM_W] == '0) begin
            overflowLimit_q[axisSel] <= wrLow;
          end
        end
        FLD_DIR: dir_q[axisSel] <= regWrData[0];
        FLD_MAXSPEED: begin
          if (regWrData[SPD_W-1:0] != '0 && regWrData[SPD_W-1:0] <= MAXSPEED_MAX
              && regWrData[31:SPD_W] == '0) begin
            maxSpeed_q[axisSel] <= regWrData[SPD_W-1:0];
          end
        end
        FLD_HOME_L, FLD_HOME_M: begin
          if (wrLow >= HOME_MIN && wrLow <= HOME_LM_MAX && regWrData[31:LIM_W] == '0) begin
            homeTenths_q[axisSel][fieldSel[1:0] - 2'h1] <= wrLow;
          end
        end
        FLD_HOME_H: begin
          if (wrLow >= HOME_MIN && wrLow <= HOME_H_MAX && regWrData[31:LIM_W] == '0) begin
            homeTenths_q[axisSel][2] <= wrLow;
          end
        end
        FLD_METHOD: begin
          if (regWrData[2:0] <= METHOD_MAX && regWrData[31:3] == '0) begin
            method_q[axisSel] <= regWrData[2:0];
          end
        end
        FLD_SENSLOG: sensLogic_q[axisSel] <= regWrData[0];
        FLD_TASK:    task_q[axisSel]      <= regWrData[TASK_W-1:0];
        default: ;
      endcase
    end
  end

  // Global control: used-axis mask and interrupt mask
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      used_q    <= RST_USED;
      irqMask_q <= '0;
    end else if (globalWr) begin
      if (fieldSel == GLB_USED) begin
        used_q <= regWrData[AXES-1:0];
      end
      if (fieldSel == GLB_IRQ_MASK) begin
        irqMask_q <= regWrData[IRQ_W-1:0];
      end
    end
  end

  // Last executed table select, entry 5 until one arrives
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      homeAccelIndex_q <= RST_ACCEL;
    end else if (accelTableSelectCommand) begin
      homeAccelIndex_q <= accelTableIndex;
    end
  end

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : gAxis
      axis_check uCheck (
        .clk          (clk),
        .rstN         (rstN),
        .targetPos    (targetPos[g]),
        .currentPos   (currentPos[g]),
        .cmdReached   (cmdReached[g]),
        .moveNegative (moveNegative[g]),
        .cmdSpeed     (cmdSpeed[g]),
        .dirSetting   (dir_q[g]),
        .maxSpeed     (maxSpeed_q[g]),
        .inPosLimit   (inPosLimit_q[g]),
        .overflowLimit(overflowLimit_q[g]),
        .inPosition_q (inPosition[g]),
        .overflow_q   (overflowErr[g]),
        .motorCcw_q   (motorCcw[g]),
        .speedOut_q   (speedOut[g])
      );
      assign effLabel[g] = used_q[g] ? label_q[g] : LABEL_NONE;
    end
  endgenerate

  // Derived per-axis outputs; homing speeds are not held under the ceiling
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      originDetected_q <= '0;
      displayLabel_q   <= {AXES{LABEL_NONE}};
      homeMethod_q     <= '0;
      homeSpeedLow_q   <= '0;
      homeSpeedMed_q   <= '0;
      homeSpeedHigh_q  <= '0;
    end else begin
      for (int i = 0; i < AXES; i++) begin
        originDetected_q[i] <= originSync_q[i] ^ sensLogic_q[i];
        displayLabel_q[i]   <= effLabel[i];
        homeMethod_q[i]     <= (method_q[i] == METHOD_ALIAS) ? 3'h0 : method_q[i];
        homeSpeedLow_q[i]   <= SPD_W'(homeTenths_q[i][0] / TENTHS_DIV);
        homeSpeedMed_q[i]   <= SPD_W'(homeTenths_q[i][1] / TENTHS_DIV);
        homeSpeedHigh_q[i]  <= SPD_W'(homeTenths_q[i][2] / TENTHS_DIV);
      end
    end
  end

  label_arbiter uArbiter (
    .labels  (effLabel),
    .tasks   (task_q),
    .cmdLabel(cmdLabel),
    .cmdTask (cmdTask),
    .hit     (routeHit)
  );

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      servoOnCommand_q   <= '0;
      servoOffCommand_q  <= '0;
      outputSetCommand_q <= '0;
    end else begin
      servoOnCommand_q   <= (cmdValid && cmdKind == SERVO_ON_COMMAND) ? routeHit : '0;
      servoOffCommand_q  <= (cmdValid && cmdKind == SERVO_OFF_COMMAND) ? routeHit : '0;
      outputSetCommand_q <= (cmdValid && cmdKind == OUTPUT_SET_COMMAND) ? routeHit : '0;
    end
  end

  // Events: overflow rising in the high half, in-position rising in the low half
  assign irqEvents = {overflowErr & ~overflowPrev_q, inPosition & ~inPosPrev_q};
  assign irq       = |(irqStatus_q & irqMask_q);

  // A set in the same cycle as the clearing read survives
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      inPosPrev_q    <= '0;
      overflowPrev_q <= '0;
      irqStatus_q    <= '0;
    end else begin
      inPosPrev_q    <= inPosition;
      overflowPrev_q <= overflowErr;
      irqStatus_q    <= (statusRd ? '0 : irqStatus_q) | irqEvents;
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdData_q <= '0;
    end else begin
      regRdData_q <= '0;
      if (regRd && !regAddr[7] && blockSel < GLOBAL_BLOCK) begin
        unique case (fieldSel)
          FLD_LABEL:    regRdData_q <= DATA_W'(label_q[axisSel]);
          FLD_INPOS:    regRdData_q <= DATA_W'(inPosLimit_q[axisSel]);
          FLD_OVERFLOW: regRdData_q <= DATA_W'(overflowLimit_q[axisSel]);
          FLD_DIR:      regRdData_q <= DATA_W'(dir_q[axisSel]);
          FLD_MAXSPEED: regRdData_q <= DATA_W'(maxSpeed_q[axisSel]);
          FLD_HOME_L:   regRdData_q <= DATA_W'(homeTenths_q[axisSel][0]);
          FLD_HOME_M:   regRdData_q <= DATA_W'(homeTenths_q[axisSel][1]);
          FLD_HOME_H:   regRdData_q <= DATA_W'(homeTenths_q[axisSel][2]);
          FLD_METHOD:   regRdData_q <= DATA_W'(method_q[axisSel]);
          FLD_SENSLOG:  regRdData_q <= DATA_W'(sensLogic_q[axisSel]);
          FLD_TASK:     regRdData_q <= DATA_W'(task_q[axisSel]);
          FLD_STATUS:   regRdData_q <= DATA_W'({originDetected_q[axisSel],
                                                overflowErr[axisSel], inPosition[axisSel]});
          default:      regRdData_q <= '0;
        endcase
      end else if (regRd && !regAddr[7] && blockSel == GLOBAL_BLOCK) begin
        unique case (fieldSel)
          GLB_IRQ_STAT: regRdData_q <= DATA_W'(irqStatus_q);
          GLB_IRQ_MASK: regRdData_q <= DATA_W'(irqMask_q);
          GLB_USED:     regRdData_q <= DATA_W'(used_q);
          GLB_ACCEL:    regRdData_q <= DATA_W'(homeAccelIndex_q);
          default:      regRdData_q <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  AST_ACCEL_FOLLOWS: assert property (accelTableSelectCommand |=>
      homeAccelIndex_q == $past(accelTableIndex))
    else $error("high-speed homing table not taken from last select");
  AST_ACCEL_HOLDS: assert property (!accelTableSelectCommand |=> $stable(homeAccelIndex_q))
    else $error("homing table changed without a select command");
  AST_METHOD_ALIAS: assert property (homeMethod_q[0] <= 3'h3 && method_q[0] <= METHOD_MAX)
    else $error("method code outside accepted set");
  // The edge that leaves reset still loads the cleared output, so it is skipped
  AST_ORIGIN_POLARITY: assert property ($past(rstN) && sensLogic_q[0] && !originSync_q[0]
      && $stable(sensLogic_q[0]) |=> originDetected_q[0])
    else $error("low sensor output not seen as origin under polarity 1");
  AST_UNUSED_LABEL: assert property (!used_q[1] |=> displayLabel_q[1] == LABEL_NONE)
    else $error("unused axis shows a label");
  AST_ROUTE_ONEHOT: assert property (##1 $onehot0(servoOnCommand_q | servoOffCommand_q
      | outputSetCommand_q))
    else $error("command routed to more than one axis");
  AST_ROUTE_LOWEST: assert property (cmdValid && cmdKind == SERVO_ON_COMMAND && routeHit[1]
      |-> !(effLabel[0] == cmdLabel && task_q[0] == cmdTask))
    else $error("higher station chosen over matching lower station");
  AST_HOME_TRUNC: assert property (homeTenths_q[0][2] == TENTHS_DIV * 16'h0064 + 16'h0009
      && $stable(homeTenths_q[0][2]) |=> homeSpeedHigh_q[0] == 14'h0064)
    else $error("home speed fraction not dropped");
  AST_HOME_RANGE: assert property (homeTenths_q[3][0] <= HOME_LM_MAX
      && homeTenths_q[3][2] <= HOME_H_MAX && homeTenths_q[3][1] >= HOME_MIN)
    else $error("home speed setting out of range");

endmodule : axis_position_supervisor

// File: hw/axis_supervisor_pkg.sv
// Shared constants, register layout and command codes of the axis supervisor
package axis_supervisor_pkg;

  // Structure
  localparam int AXES   = 4;
  localparam int POS_W  = 32;
  localparam int SPD_W  = 14;
  localparam int LIM_W  = 16;
  localparam int LBL_W  = 3;
  localparam int TASK_W = 2;
  localparam int ACC_W  = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W  = 2 * AXES;

  // Axis labels
  localparam logic [LBL_W-1:0] LABEL_X    = 3'h0;
  localparam logic [LBL_W-1:0] LABEL_Y    = 3'h1;
  localparam logic [LBL_W-1:0] LABEL_Z    = 3'h2;
  localparam logic [LBL_W-1:0] LABEL_R    = 3'h3;
  localparam logic [LBL_W-1:0] LABEL_NONE = 3'h4;

  // Address layout: addr[6:4] selects an axis block (0..3) or the global block (4)
  localparam logic [2:0] GLOBAL_BLOCK = 3'h4;
  localparam logic [3:0] FLD_LABEL    = 4'h0;
  localparam logic [3:0] FLD_INPOS    = 4'h1;
  localparam logic [3:0] FLD_OVERFLOW = 4'h2;
  localparam logic [3:0] FLD_DIR      = 4'h3;
  localparam logic [3:0] FLD_MAXSPEED = 4'h4;
  localparam logic [3:0] FLD_HOME_L   = 4'h5;
  localparam logic [3:0] FLD_HOME_M   = 4'h6;
  localparam logic [3:0] FLD_HOME_H   = 4'h7;
  localparam logic [3:0] FLD_METHOD   = 4'h8;
  localparam logic [3:0] FLD_SENSLOG  = 4'h9;
  localparam logic [3:0] FLD_TASK     = 4'ha;
  localparam logic [3:0] FLD_STATUS   = 4'hb;
  localparam logic [3:0] GLB_IRQ_STAT = 4'h0;
  localparam logic [3:0] GLB_IRQ_MASK = 4'h1;
  localparam logic [3:0] GLB_USED     = 4'h2;
  localparam logic [3:0] GLB_ACCEL    = 4'h3;

  // Values after reset; home speeds are held in tenths of mm/s
  localparam logic [LIM_W-1:0]  RST_INPOS    = 16'h0005;
  localparam logic [LIM_W-1:0]  RST_OVERFLOW = 16'h4e20;
  localparam logic [SPD_W-1:0]  RST_MAXSPEED = 14'h04b0;
  localparam logic [LIM_W-1:0]  RST_HOME_L   = 16'h0014;
  localparam logic [LIM_W-1:0]  RST_HOME_M   = 16'h00c8;
  localparam logic [LIM_W-1:0]  RST_HOME_H   = 16'h03e8;
  localparam logic [2:0]        RST_METHOD   = 3'h0;
  localparam logic              RST_DIR      = 1'b1;
  localparam logic              RST_SENSLOG  = 1'b1;
  localparam logic [AXES-1:0]   RST_USED     = 4'h1;
  localparam logic [ACC_W-1:0]  RST_ACCEL    = 4'h5;

  // Accepted ranges
  localparam logic [LIM_W-1:0] INPOS_MAX     = 16'h1964;
  localparam logic [SPD_W-1:0] MAXSPEED_MAX  = 14'h270f;
  localparam logic [LIM_W-1:0] HOME_MIN      = 16'h000a;
  localparam logic [LIM_W-1:0] HOME_LM_MAX   = 16'h09c4;
  localparam logic [LIM_W-1:0] HOME_H_MAX    = 16'h2706;
  localparam logic [LIM_W-1:0] TENTHS_DIV    = 16'h000a;
  localparam logic [2:0]       METHOD_MAX    = 3'h4;
  localparam logic [2:0]       METHOD_ALIAS  = 3'h4;

  typedef enum logic [1:0] {
    SERVO_ON_COMMAND,
    SERVO_OFF_COMMAND,
    OUTPUT_SET_COMMAND
  } command_type;

endpackage : axis_supervisor_pkg

// File: hw/label_arbiter.sv
// Picks the lowest-station axis whose label and task match a command
`timescale 1ns/1ps
module label_arbiter
  import axis_supervisor_pkg::*;
(
  // Axis attributes
  input  wire logic [AXES-1:0][LBL_W-1:0]  labels,
  input  wire logic [AXES-1:0][TASK_W-1:0] tasks,
  // Command
  input  wire logic [LBL_W-1:0]            cmdLabel,
  input  wire logic [TASK_W-1:0]           cmdTask,
  // One-hot target
  output logic [AXES-1:0]                  hit
);

  // Scanning downward lets the lowest matching station win
  always_comb begin
    hit = '0;
    for (int i = AXES - 1; i >= 0; i--) begin
      if (labels[i] == cmdLabel && tasks[i] == cmdTask && cmdLabel != LABEL_NONE) begin
        hit = '0;
        hit[i] = 1'b1;
      end
    end
  end

endmodule : label_arbiter

// File: tb/servo_partner.sv
// Behavioural servo axes: encoder lags the target, origin sensor per axis
`timescale 1ns/1ps
module servo_partner
  import axis_supervisor_pkg::*;
(
  // Clock
  input  wire logic                       clk,
  // Bench controls
  input  wire logic [AXES-1:0][POS_W-1:0] targetPos,
  input  wire logic [AXES-1:0][POS_W-1:0] lag,
  input  wire logic [AXES-1:0]            atHome,
  // Encoder and sensor
  output logic [AXES-1:0][POS_W-1:0]      currentPos,
  output logic [AXES-1:0]                 originSensor
);
  // Sensors switch off on detection, so only polarity 1 sees them as found
  always_ff @(posedge clk) begin
    for (int i = 0; i < AXES; i++) begin
      currentPos[i]   <= targetPos[i] - lag[i];
      originSensor[i] <= ~atHome[i];
    end
  end
endmodule : servo_partner

// File: tb/tb_axis_position_supervisor.sv
// Self-checking bench for the axis positioning supervisor
`timescale 1ns/1ps
module tb_axis_position_supervisor;
  import axis_supervisor_pkg::*;
  logic clk = 0, reset_n = 0, regWr = 0, regRd = 0, cmdValid = 0;
  logic accelTableSelectCommand = 0, irq;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0, regRdData_q;
  logic [AXES-1:0][POS_W-1:0] targetPos = '0, lag = '0, currentPos;
  logic [AXES-1:0] cmdReached = '0, moveNegative = '0, atHome = '0, originSensor;
  logic [AXES-1:0] inPosition, overflowErr, motorCcw, originDetected_q;
  logic [AXES-1:0] servoOnCommand_q, servoOffCommand_q, outputSetCommand_q;
  logic [AXES-1:0][SPD_W-1:0] cmdSpeed = '0, speedOut;
  logic [AXES-1:0][SPD_W-1:0] homeSpeedLow_q, homeSpeedMed_q, homeSpeedHigh_q;
  logic [AXES-1:0][LBL_W-1:0] displayLabel_q;
  logic [AXES-1:0][2:0] homeMethod_q;
  command_type cmdKind = SERVO_ON_COMMAND;
  logic [LBL_W-1:0] cmdLabel = '0;
  logic [TASK_W-1:0] cmdTask = '0;
  logic [ACC_W-1:0] accelTableIndex = '0, homeAccelIndex_q;
  int n_mismatch = 0, check_count = 0;
  always #12.5 clk = ~clk;
  servo_partner motor (.clk, .targetPos, .lag, .atHome, .currentPos, .originSensor);
  axis_position_supervisor DUT (.clk, .reset_n, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData_q, .targetPos, .currentPos, .cmdReached, .moveNegative, .cmdSpeed,
    .cmdValid, .cmdKind, .cmdLabel, .cmdTask, .accelTableSelectCommand,
    .accelTableIndex, .originSensor, .inPosition, .overflowErr, .motorCcw, .speedOut,
    .originDetected_q, .displayLabel_q, .homeMethod_q, .homeSpeedLow_q, .homeSpeedMed_q,
    .homeSpeedHigh_q, .homeAccelIndex_q, .servoOnCommand_q, .servoOffCommand_q,
    .outputSetCommand_q, .irq);
  task automatic chk(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp, string m);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t ns: %s", $time, m);
    end
  endtask : chk
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so callers look at once
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
  endtask : rd
  task automatic t_regs;
    rd(8'h14);
    chk(regRdData_q, 32'h4b0, "max speed reset");
    rd(8'h7f);
    chk(regRdData_q, 32'h0, "unmapped read");
    chk(homeAccelIndex_q, 32'h5, "accel default");
    chk(motorCcw[0], 32'h1, "direction reset");
    @(posedge clk);
    accelTableSelectCommand <= 1'b1;
    accelTableIndex <= 4'h9;
    @(posedge clk);
    accelTableSelectCommand <= 1'b0;
    wt(1);
    chk(homeAccelIndex_q, 32'h9, "accel select");
    $display("regs done");
  endtask : t_regs
  task automatic t_motion;
    wr(8'h04, 32'h64);
    wr(8'h04, 32'h2710);
    wr(8'h12, 32'ha);
    wr(8'h03, 32'h0);
    @(posedge clk);
    cmdSpeed[0] <= 14'h00c8;
    cmdSpeed[1] <= 14'h00c8;
    moveNegative[1] <= 1'b1;
    targetPos[0] <= 32'h64;
    lag[0] <= 32'h3;
    targetPos[1] <= 32'hb;
    lag[1] <= 32'ha;
    wt(4);
    chk(speedOut[0], 32'h64, "speed capped");
    chk(speedOut[1], 32'hc8, "speed free");
    chk(motorCcw[0], 32'h0, "forward");
    chk(motorCcw[1], 32'h0, "reverse negative");
    chk(inPosition[0], 32'h0, "not reached");
    chk(overflowErr[1], 32'h0, "at limit");
    chk(irq, 32'h0, "masked idle");
    wr(8'h41, 32'h1);
    @(posedge clk);
    cmdReached[0] <= 1'b1;
    lag[1] <= 32'hb;
    wt(4);
    chk(inPosition[0], 32'h1, "in position");
    chk(overflowErr[1], 32'h1, "overflow");
    chk(overflowErr[0], 32'h0, "axis isolation");
    chk(irq, 32'h1, "irq up");
    rd(8'h40);
    chk(regRdData_q, 32'h21, "irq status");
    wt(1);
    chk(irq, 32'h0, "irq cleared");
    lag[0] <= 32'h5;
    wt(4);
    chk(inPosition[0], 32'h0, "threshold edge");
    wr(8'h01, 32'h1964);
    cmdReached[0] <= 1'b0;
    lag[0] <= 32'h1;
    wt(4);
    chk(inPosition[0], 32'h0, "no bypass");
    $display("motion done");
  endtask : t_motion
  task automatic t_home;
    wr(8'h07, 32'h3f1);
    wr(8'h05, 32'h9c5);
    wr(8'h08, 32'h4);
    wr(8'h18, 32'h3);
    atHome[0] <= 1'b1;
    wt(5);
    chk(homeSpeedHigh_q[0], 32'h64, "truncated");
    chk(homeSpeedLow_q[0], 32'h2, "low range");
    chk(homeSpeedMed_q[0], 32'h14, "medium default");
    chk(homeMethod_q[0], 32'h0, "method alias");
    chk(homeMethod_q[1], 32'h3, "method kept");
    chk(originDetected_q[0], 32'h1, "sensor off");
    wr(8'h09, 32'h0);
    wt(2);
    chk(originDetected_q[0], 32'h0, "polarity");
    $display("home done");
  endtask : t_home
  task automatic t_label;
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h42, 32'h3);
    wt(2);
    chk(displayLabel_q[2], 32'h4, "unused label");
    chk(displayLabel_q[1], 32'h0, "used label");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdKind <= command_type'(k);
      @(posedge clk);
      cmdValid <= 1'b0;
      #1;
      chk({outputSetCommand_q, servoOffCommand_q, servoOnCommand_q}, 1 << (4 * k),
          "routing");
    end
    // Axis 1 alone in task 1 must take the command although axis 0 shares its label
    wr(8'h1a, 32'h1);
    cmdTask <= 2'h1;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdKind <= SERVO_ON_COMMAND;
    @(posedge clk);
    cmdValid <= 1'b0;
    #1;
    chk(servoOnCommand_q, 32'h2, "task match");
    $display("label done");
  endtask : t_label
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    wt(4);
    t_regs();
    t_motion();
    t_home();
    t_label();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule : tb_axis_position_supervisor
